// >>> pkg/adc_cfg_pkg.sv
/*
 * adc_cfg_pkg: register offsets, field positions, reset values and decoded
 * setting tables for configuration registers one to three.
 * Assumes an AXI4-Lite slave with 32-bit data, one aligned word per register.
 */
package adc_cfg_pkg;

    // =====================================================================
    // register map (printed offsets are not multiples of four: indices)
    // =====================================================================
    localparam logic [7:0] RATE_MODE_REFERENCE_CONFIG_IDX      = 8'h01;
    localparam logic [7:0] STATUS_INTEGRITY_CURRENT_CONFIG_IDX = 8'h02;
    localparam logic [7:0] CURRENT_ROUTING_CONFIG_IDX          = 8'h03;
    localparam int         ADDR_W                              = 8;
    localparam int         IDX_LSB                             = 2;

    localparam logic [7:0] CFG_RESET = 8'h00;

    // =====================================================================
    // field positions of register one
    // =====================================================================
    localparam int RATE_MSB  = 7;
    localparam int RATE_LSB  = 5;
    localparam int SPEED_BIT = 4;
    localparam int CONT_BIT  = 3;
    localparam int REF_MSB   = 2;
    localparam int REF_LSB   = 1;
    localparam int TEMP_BIT  = 0;

    // =====================================================================
    // field positions of registers two and three
    // =====================================================================
    localparam int READY_BIT   = 7;
    localparam int COUNTER_BIT = 6;
    localparam int CHECK_MSB   = 5;
    localparam int CHECK_LSB   = 4;
    localparam int BURNOUT_BIT = 3;
    localparam int LEVEL_MSB   = 2;
    localparam int LEVEL_LSB   = 0;
    localparam int ROUTE1_MSB  = 7;
    localparam int ROUTE1_LSB  = 5;
    localparam int ROUTE2_MSB  = 4;
    localparam int ROUTE2_LSB  = 2;
    localparam logic [7:0] ROUTING_WRITE_MASK = 8'hfc;
    localparam logic [7:0] STATUS_WRITE_MASK  = 8'h7f;

    // =====================================================================
    // decoded settings
    // =====================================================================
    typedef enum logic [1:0] {
        REF_INTERNAL = 2'h0,
        REF_EXTERNAL = 2'h1,
        REF_SUPPLY   = 2'h2
    } ref_source_t;

    typedef enum logic [1:0] {
        CHECK_OFF      = 2'h0,
        CHECK_INVERTED = 2'h1,
        CHECK_CRC16    = 2'h2,
        CHECK_RESERVED = 2'h3
    } check_mode_t;

    localparam logic [11:0] RATE_RESERVED_SPS = 12'h000;
    localparam logic [11:0] NORMAL_SPS [8] = '{
        12'h014, 12'h02d, 12'h05a, 12'h0af, 12'h14a, 12'h258, 12'h3e8, 12'h000};
    localparam logic [11:0] FAST_SPS [8] = '{
        12'h028, 12'h05a, 12'h0b4, 12'h15e, 12'h294, 12'h4b0, 12'h7d0, 12'h000};
    localparam logic [9:0] MOD_NORMAL_KHZ = 10'h100;
    localparam logic [9:0] MOD_FAST_KHZ   = 10'h200;
    localparam logic [10:0] LEVEL_UA [8] = '{
        11'h000, 11'h00a, 11'h032, 11'h064, 11'h0fa, 11'h1f4, 11'h3e8, 11'h5dc};
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage

// >>> core/adc_cfg_regs.sv
/*
 * adc_cfg_regs: configuration registers one to three with an AXI4-Lite slave,
 * decoding the fields into settings for the converter core.
 * Assumes the converter core gives a one-cycle new-result pulse and a one-cycle
 * data-read pulse on CLK; unmapped addresses answer SLVERR.
 */
`timescale 1ns/1ps

// Overview of operation
// - rate code picks normal-mode output rate
// - same codes double rate in fast mode
// - speed bit picks 256 or 512 kHz
// - mode bit picks single-shot or continuous
// - reference field picks internal, external, supply
// - temperature mode ignores register zero, internal reference
// - ready flag set by result, cleared on read
// - counter bit enables conversion data counter
// - integrity field picks none, inverted, crc16
// - burn-out bit switches 10 uA sources
// - level field sets both excitation currents
// - routing field one steers first source
// - routing field two steers second source
// - all three registers reset to zero
module adc_cfg_regs (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        RESULT_NEW,
    input  wire logic        RESULT_READ,
    output logic [11:0]      SAMPLE_RATE_SPS,
    output logic             RATE_RESERVED,
    output logic [9:0]       MODULATOR_KHZ,
    output logic             CONTINUOUS_SELECT,
    output logic [1:0]       REFERENCE_SOURCE,
    output logic             TEMPERATURE_SENSOR_ENABLE,
    output logic             REGISTER_ZERO_IGNORE,
    output logic             RESULT_READY_FLAG,
    output logic             CONVERSION_COUNTER_ENABLE,
    output logic [1:0]       INTEGRITY_MODE,
    output logic             BURNOUT_SOURCE_ENABLE,
    output logic [10:0]      EXCITATION_CURRENT_UA,
    output logic [2:0]       SOURCE_ONE_ROUTING,
    output logic [2:0]       SOURCE_TWO_ROUTING
);

    // =====================================================================
    // storage
    // =====================================================================
    logic [7:0]  rate_mode_reference_config_q;
    logic [7:0]  status_integrity_current_config_q;
    logic [7:0]  current_routing_config_q;
    logic        ready_q;
    logic        aw_held_q;
    logic        w_held_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        do_write;
    logic [7:0]  wr_idx;
    logic [7:0]  rd_idx;
    logic [7:0]  rd_byte;
    logic        rd_hit;
    logic        wr_hit;
    logic        do_read;

    // =====================================================================
    // write channel
    // =====================================================================
    // address and data are latched independently so either may arrive first
    assign S_AXI_AWREADY = !aw_held_q && !bvalid_q;
    assign S_AXI_WREADY  = !w_held_q && !bvalid_q;
    assign S_AXI_BVALID  = bvalid_q;
    assign S_AXI_BRESP   = bresp_q;
    assign do_write      = aw_held_q && w_held_q && !bvalid_q;
    assign wr_idx        = {2'h0, aw_addr_q[adc_cfg_pkg::ADDR_W-1:adc_cfg_pkg::IDX_LSB]};
    assign wr_hit        = (wr_idx == adc_cfg_pkg::RATE_MODE_REFERENCE_CONFIG_IDX)
                        || (wr_idx == adc_cfg_pkg::STATUS_INTEGRITY_CURRENT_CONFIG_IDX)
                        || (wr_idx == adc_cfg_pkg::CURRENT_ROUTING_CONFIG_IDX);

    // address and data capture; both drop once the answer is taken
    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
            end else if (bvalid_q && S_AXI_BREADY) begin
                aw_held_q <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_q <= 1'b1;
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
            end else if (bvalid_q && S_AXI_BREADY) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // write response, one cycle after both halves are held
    always_ff @(posedge CLK) begin
        if (RST) begin
            bvalid_q <= 1'b0;
            bresp_q  <= adc_cfg_pkg::AXI_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? adc_cfg_pkg::AXI_OKAY : adc_cfg_pkg::AXI_SLVERR;
        end else if (bvalid_q && S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // =====================================================================
    // configuration registers
    // =====================================================================
    // zero at reset
    // only byte lane 0 carries data; the upper lanes read as zero anyway
    always_ff @(posedge CLK) begin
        if (RST) begin
            rate_mode_reference_config_q      <= adc_cfg_pkg::CFG_RESET;
            status_integrity_current_config_q <= adc_cfg_pkg::CFG_RESET;
            current_routing_config_q          <= adc_cfg_pkg::CFG_RESET;
        end else if (do_write && w_strb_q[0]) begin
            case (wr_idx)
                adc_cfg_pkg::RATE_MODE_REFERENCE_CONFIG_IDX: begin
                    rate_mode_reference_config_q <= w_data_q[7:0];
                end
                adc_cfg_pkg::STATUS_INTEGRITY_CURRENT_CONFIG_IDX: begin
                    // ready bit is read-only; masked out of the stored copy
                    status_integrity_current_config_q <=
                        w_data_q[7:0] & adc_cfg_pkg::STATUS_WRITE_MASK;
                end
                adc_cfg_pkg::CURRENT_ROUTING_CONFIG_IDX: begin
                    current_routing_config_q <=
                        w_data_q[7:0] & adc_cfg_pkg::ROUTING_WRITE_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // ready flag update
    // a new result in the same cycle as a data read wins, so none is lost
    always_ff @(posedge CLK) begin
        if (RST) begin
            ready_q <= 1'b0;
        end else if (RESULT_NEW) begin
            ready_q <= 1'b1;
        end else if (RESULT_READ) begin
            ready_q <= 1'b0;
        end
    end

    // =====================================================================
    // read channel
    // =====================================================================
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RDATA   = rdata_q;
    assign S_AXI_RRESP   = rresp_q;
    assign do_read       = S_AXI_ARVALID && !rvalid_q;
    assign rd_idx        = {2'h0, S_AXI_ARADDR[adc_cfg_pkg::ADDR_W-1:adc_cfg_pkg::IDX_LSB]};

    // read mux; register two shows the live ready flag in its top bit
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        case (rd_idx)
            adc_cfg_pkg::RATE_MODE_REFERENCE_CONFIG_IDX: begin
                rd_byte = rate_mode_reference_config_q;
            end
            adc_cfg_pkg::STATUS_INTEGRITY_CURRENT_CONFIG_IDX: begin
                rd_byte = status_integrity_current_config_q;
                rd_byte[adc_cfg_pkg::READY_BIT] = ready_q;
            end
            adc_cfg_pkg::CURRENT_ROUTING_CONFIG_IDX: begin
                rd_byte = current_routing_config_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge CLK) begin
        if (RST) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= adc_cfg_pkg::AXI_OKAY;
        end else if (do_read) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= rd_hit ? adc_cfg_pkg::AXI_OKAY : adc_cfg_pkg::AXI_SLVERR;
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // =====================================================================
    // decoded settings, registered so outputs come from flip-flops
    // =====================================================================
    always_ff @(posedge CLK) begin
        if (RST) begin
            SAMPLE_RATE_SPS           <= 12'h000;
            RATE_RESERVED             <= 1'b0;
            MODULATOR_KHZ             <= 10'h000;
            CONTINUOUS_SELECT         <= 1'b0;
            REFERENCE_SOURCE          <= adc_cfg_pkg::REF_INTERNAL;
            TEMPERATURE_SENSOR_ENABLE <= 1'b0;
            REGISTER_ZERO_IGNORE      <= 1'b0;
        end else begin
            if (rate_mode_reference_config_q[adc_cfg_pkg::SPEED_BIT]) begin
                SAMPLE_RATE_SPS <= adc_cfg_pkg::FAST_SPS[
                    rate_mode_reference_config_q[adc_cfg_pkg::RATE_MSB:adc_cfg_pkg::RATE_LSB]];
            end else begin
                SAMPLE_RATE_SPS <= adc_cfg_pkg::NORMAL_SPS[
                    rate_mode_reference_config_q[adc_cfg_pkg::RATE_MSB:adc_cfg_pkg::RATE_LSB]];
            end
            RATE_RESERVED <= &rate_mode_reference_config_q[adc_cfg_pkg::RATE_MSB:
                                                           adc_cfg_pkg::RATE_LSB];
            MODULATOR_KHZ <= rate_mode_reference_config_q[adc_cfg_pkg::SPEED_BIT]
                           ? adc_cfg_pkg::MOD_FAST_KHZ : adc_cfg_pkg::MOD_NORMAL_KHZ;
            CONTINUOUS_SELECT <= rate_mode_reference_config_q[adc_cfg_pkg::CONT_BIT];
            // reference selection, forced internal in temperature mode
            if (rate_mode_reference_config_q[adc_cfg_pkg::TEMP_BIT]) begin
                REFERENCE_SOURCE <= adc_cfg_pkg::REF_INTERNAL;
            end else if (rate_mode_reference_config_q[adc_cfg_pkg::REF_MSB]) begin
                REFERENCE_SOURCE <= adc_cfg_pkg::REF_SUPPLY;
            end else begin
                REFERENCE_SOURCE <= rate_mode_reference_config_q[adc_cfg_pkg::REF_LSB]
                                  ? adc_cfg_pkg::REF_EXTERNAL : adc_cfg_pkg::REF_INTERNAL;
            end
            TEMPERATURE_SENSOR_ENABLE <= rate_mode_reference_config_q[adc_cfg_pkg::TEMP_BIT];
            REGISTER_ZERO_IGNORE      <= rate_mode_reference_config_q[adc_cfg_pkg::TEMP_BIT];
        end
    end

    // register two and three settings
    always_ff @(posedge CLK) begin
        if (RST) begin
            RESULT_READY_FLAG         <= 1'b0;
            CONVERSION_COUNTER_ENABLE <= 1'b0;
            INTEGRITY_MODE            <= adc_cfg_pkg::CHECK_OFF;
            BURNOUT_SOURCE_ENABLE     <= 1'b0;
            EXCITATION_CURRENT_UA     <= 11'h000;
            SOURCE_ONE_ROUTING        <= 3'h0;
            SOURCE_TWO_ROUTING        <= 3'h0;
        end else begin
            RESULT_READY_FLAG <= ready_q;
            CONVERSION_COUNTER_ENABLE <=
                status_integrity_current_config_q[adc_cfg_pkg::COUNTER_BIT];
            INTEGRITY_MODE <= status_integrity_current_config_q[adc_cfg_pkg::CHECK_MSB:
                                                                adc_cfg_pkg::CHECK_LSB];
            BURNOUT_SOURCE_ENABLE <= status_integrity_current_config_q[adc_cfg_pkg::BURNOUT_BIT];
            EXCITATION_CURRENT_UA <= adc_cfg_pkg::LEVEL_UA[
                status_integrity_current_config_q[adc_cfg_pkg::LEVEL_MSB:adc_cfg_pkg::LEVEL_LSB]];
            // routing passed as codes; reserved code left to the host
            SOURCE_ONE_ROUTING <= current_routing_config_q[adc_cfg_pkg::ROUTE1_MSB:
                                                           adc_cfg_pkg::ROUTE1_LSB];
            SOURCE_TWO_ROUTING <= current_routing_config_q[adc_cfg_pkg::ROUTE2_MSB:
                                                           adc_cfg_pkg::ROUTE2_LSB];
        end
    end

endmodule

// >>> tb/adc_cfg_regs_chk.sv
/* Port checker for adc_cfg_regs: bus handshakes, ready flag, reset state.
   Assumes CLK and synchronous active-high RST; bound below. */
`timescale 1ns/1ps
// =====================================================================
// checker
module adc_cfg_regs_chk (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic        RESULT_NEW,
    input wire logic        RESULT_READ,
    input wire logic        RESULT_READY_FLAG,
    input wire logic        TEMPERATURE_SENSOR_ENABLE,
    input wire logic [1:0]  REFERENCE_SOURCE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // a write whose address and data are taken together
    sequence s_wr_taken; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    // a clear pulse with no new result beside it or just after it
    sequence s_clear_only; RESULT_READ && !RESULT_NEW ##1 !RESULT_NEW; endsequence
    property p_wr_resp; s_wr_taken |-> ##[1:2] S_AXI_BVALID; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
    property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd_resp; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
    property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_r_busy; S_AXI_RVALID |-> !S_AXI_ARREADY && S_AXI_RDATA[31:8] == 24'h0; endproperty
    a_r_busy: assert property (p_r_busy) else $error("read channel misbehaves");
    property p_ready_set; RESULT_NEW |-> ##2 RESULT_READY_FLAG; endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set");
    property p_ready_clr; s_clear_only |-> ##1 !RESULT_READY_FLAG; endproperty
    a_ready_clr: assert property (p_ready_clr) else $error("ready not cleared");
    property p_temp_ref; TEMPERATURE_SENSOR_ENABLE |-> REFERENCE_SOURCE == 2'h0; endproperty
    a_temp_ref: assert property (p_temp_ref) else $error("temp mode ref wrong");
    property p_reset; disable iff (1'b0) RST ##1 RST |-> !S_AXI_BVALID && !S_AXI_RVALID
        && !RESULT_READY_FLAG && !TEMPERATURE_SENSOR_ENABLE; endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule

bind adc_cfg_regs adc_cfg_regs_chk i_chk (.CLK, .RST, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .RESULT_NEW, .RESULT_READ,
    .RESULT_READY_FLAG, .TEMPERATURE_SENSOR_ENABLE, .REFERENCE_SOURCE);

// >>> tb/adc_core_model.sv
/* Converter core stand-in: turns bench requests into one-cycle events.
   Assumes requests last one CLK cycle. */
`timescale 1ns/1ps
// =====================================================================
// core events
module adc_core_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic req_new,
    input  wire logic req_read,
    output logic      result_new,
    output logic      result_read
);
    // registered so the pulses leave just after an edge, as the core's do
    // result events
    always_ff @(posedge clk) begin
        result_new  <= !rst && req_new;
        result_read <= !rst && req_read;
    end
endmodule

// >>> tb/adc_config_registers_one_to_three_tb.sv
/* Self-checking bench for adc_cfg_regs with an integer register model.
   Assumes the core stand-in and the bound checker. */
`timescale 1ns/1ps
// =====================================================================
// bench
module adc_config_registers_one_to_three_tb;
    logic        CLK = 1'b0, RST = 1'b1, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
    logic        S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic        req_new = 1'b0, req_read = 1'b0;
    logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
    logic [3:0]  S_AXI_WSTRB = 4'h0;
    logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic        RESULT_NEW, RESULT_READ, RATE_RESERVED, CONTINUOUS_SELECT, RESULT_READY_FLAG;
    logic        TEMPERATURE_SENSOR_ENABLE, REGISTER_ZERO_IGNORE;
    logic        CONVERSION_COUNTER_ENABLE, BURNOUT_SOURCE_ENABLE;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, REFERENCE_SOURCE, INTEGRITY_MODE;
    logic [11:0] SAMPLE_RATE_SPS;
    logic [9:0]  MODULATOR_KHZ;
    logic [10:0] EXCITATION_CURRENT_UA;
    logic [2:0]  SOURCE_ONE_ROUTING, SOURCE_TWO_ROUTING;
    int          n_mismatch = 0, checked = 0, seed = 32'h2ae8, rdy = 0, mdl[4] = '{0, 0, 0, 0};
    int          nsps[8] = '{20, 45, 90, 175, 330, 600, 1000, 0};
    int          fsps[8] = '{40, 90, 180, 350, 660, 1200, 2000, 0};
    int          ua[8] = '{0, 10, 50, 100, 250, 500, 1000, 1500};

    adc_core_model i_core (.clk(CLK), .rst(RST), .req_new, .req_read,
        .result_new(RESULT_NEW), .result_read(RESULT_READ));
    adc_cfg_regs i_dut (.CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
        .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
        .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
        .S_AXI_RREADY, .RESULT_NEW, .RESULT_READ, .SAMPLE_RATE_SPS, .RATE_RESERVED,
        .MODULATOR_KHZ, .CONTINUOUS_SELECT, .REFERENCE_SOURCE, .TEMPERATURE_SENSOR_ENABLE,
        .REGISTER_ZERO_IGNORE, .RESULT_READY_FLAG, .CONVERSION_COUNTER_ENABLE, .INTEGRITY_MODE,
        .BURNOUT_SOURCE_ENABLE, .EXCITATION_CURRENT_UA, .SOURCE_ONE_ROUTING, .SOURCE_TWO_ROUTING);

    // 100 MHz clock
    initial forever #5 CLK = ~CLK;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic hang;
        n_mismatch++;
        $display("[ERR] handshake expected answer seen none");
        test_done;
    endtask

    // write: address and data offered together; bready raised only once bvalid is seen,
    // which stalls the response one cycle on purpose; handshakes are judged at the
    // settled falling edge so the rising edge that changes the readies is never raced
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic aw_t, w_t, bv, b_t;
        b_t = 1'b0;
        @(posedge CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= s;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        for (int n = 0; n < 40 && !b_t; n++) begin
            @(negedge CLK);
            aw_t = S_AXI_AWVALID && S_AXI_AWREADY;
            w_t = S_AXI_WVALID && S_AXI_WREADY;
            bv = S_AXI_BVALID;
            b_t = bv && S_AXI_BREADY;
            r = S_AXI_BRESP;
            @(posedge CLK);
            if (aw_t) S_AXI_AWVALID <= 1'b0;
            if (w_t) S_AXI_WVALID <= 1'b0;
            S_AXI_BREADY <= bv && !b_t;
        end
        if (!b_t) hang;
    endtask

    // read with the same one-cycle stall on rready
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t, rv, r_t;
        r_t = 1'b0;
        @(posedge CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        for (int n = 0; n < 40 && !r_t; n++) begin
            @(negedge CLK);
            ar_t = S_AXI_ARVALID && S_AXI_ARREADY;
            rv = S_AXI_RVALID;
            r_t = rv && S_AXI_RREADY;
            d = S_AXI_RDATA;
            r = S_AXI_RRESP;
            @(posedge CLK);
            if (ar_t) S_AXI_ARVALID <= 1'b0;
            S_AXI_RREADY <= rv && !r_t;
        end
        if (!r_t) hang;
    endtask

    // decoded outputs against the model, after the one-cycle decode lag
    task automatic out_chk;
        logic [7:0] a, b, c;
        repeat (4) @(negedge CLK);
        a = mdl[1][7:0];
        b = mdl[2][7:0];
        c = mdl[3][7:0];
        chk("rate", a[4] ? fsps[a[7:5]] : nsps[a[7:5]], SAMPLE_RATE_SPS);
        chk("khz", a[4] ? 512 : 256, MODULATOR_KHZ);
        chk("ref", a[0] ? 0 : a[2] ? 2 : a[2:1], REFERENCE_SOURCE);
        chk("ua", ua[b[2:0]], EXCITATION_CURRENT_UA);
        chk("flags", {a[7:5] == 3'h7, a[3], a[0], a[0], b[6:3], c[7:2], rdy[0]},
            {RATE_RESERVED, CONTINUOUS_SELECT, TEMPERATURE_SENSOR_ENABLE, REGISTER_ZERO_IGNORE,
             CONVERSION_COUNTER_ENABLE, INTEGRITY_MODE, BURNOUT_SOURCE_ENABLE,
             SOURCE_ONE_ROUTING, SOURCE_TWO_ROUTING, RESULT_READY_FLAG});
    endtask

    // register write mirrored into the model; flag bit and low routing bits never stored
    task automatic wm(input int i, input logic [7:0] v);
        logic [1:0] r;
        wr(8'(i * 4), {24'h0, v}, 4'h1, r);
        chk("bresp", (i >= 1 && i <= 3) ? 0 : 2, r);
        if (i == 1) mdl[1] = v;
        if (i == 2) mdl[2] = v & 8'h7f;
        if (i == 3) mdl[3] = v & 8'hfc;
        out_chk;
    endtask

    task automatic rm(input int i);
        logic [31:0] d;
        logic [1:0]  r;
        rd(8'(i * 4), d, r);
        chk("rresp", (i >= 1 && i <= 3) ? 0 : 2, r);
        chk("rdata", (i == 2 ? rdy << 7 : 0) + (i < 4 ? mdl[i] : 0), d);
    endtask

    // core event pulse; a new result beats a clear in the same cycle
    task automatic ev(input logic n, input logic c);
        @(posedge CLK);
        req_new <= n;
        req_read <= c;
        @(posedge CLK);
        req_new <= 1'b0;
        req_read <= 1'b0;
        rdy = n ? 1 : c ? 0 : rdy;
        out_chk;
    endtask

    // main sequence
    initial begin
        logic [1:0] r;
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        for (int i = 1; i < 4; i++) rm(i);
        out_chk;
        $display("test reset finished");
        // reserved rate code kept out
        for (int i = 0; i < 14; i++) wm(1, 8'((i % 7) << 5 | (i / 7) << 4));
        $display("test rate finished");
        for (int i = 0; i < 16; i++) begin
            wm(1, 8'(({$random(seed)} % 7) << 5 | i));
            rm(1);
        end
        $display("test mode finished");
        // random flag and enable bits, reserved check code kept out
        for (int i = 0; i < 12; i++) begin
            wm(2, 8'({$random(seed)} & 8'hc8 | (i % 3) << 4 | i % 8));
            rm(2);
        end
        $display("test integrity finished");
        // host writes zeros to the low routing bits
        for (int i = 0; i < 7; i++) begin
            wm(3, 8'(i << 5 | (6 - i) << 2));
            rm(3);
        end
        $display("test routing finished");
        ev(1'b1, 1'b0);
        rm(2);
        ev(1'b0, 1'b1);
        rm(2);
        ev(1'b1, 1'b1);
        rm(2);
        $display("test ready finished");
        wm(0, 8'hff);
        wm(4, 8'h55);
        rm(0);
        rm(4);
        wr(8'h04, 32'h000000ff, 4'h0, r);
        chk("bresp", 32'h0, {30'h0, r});
        rm(1);
        $display("test unmapped finished");
        test_done;
    end
endmodule
